// >>> pkg/access_lock_pkg.sv
// access_lock_pkg: register map, field layout, commands and carriers for the programming access lock.
// Assumes a 32-bit APB slave, with each register taking one aligned word.
`default_nettype none
package access_lock_pkg;
   localparam int KEY_W = 128;
   localparam int KEY_WORDS = 4;
   // register byte offsets
   localparam logic [7:0] OFF_KEY0 = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_CFG = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFF_IRQ_EN = 8'h20;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h24;
   localparam logic [7:0] OFF_OP = 8'h28;
   localparam logic [7:0] OFF_SET = 8'h2C;
   // op register fields
   localparam int OP_LSB = 0;
   localparam int REG_LSB = 4;
   // cfg / set register fields
   localparam int CFG_LOCK_BIT = 0;
   localparam int CFG_PART_BIT = 1;
   localparam int CFG_PERM_LOCK_BIT = 2;
   localparam int CFG_PERM_SET_BIT = 3;
   localparam int CFG_ENC_BIT = 4;
   localparam int CFG_ENC_REG_LSB = 8;
   // status register fields
   localparam int ST_GRANT_BIT = 0;
   localparam int ST_REFUSE_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_LAST_OK_BIT = 3;
   // interrupt register fields
   localparam int IRQ_GRANT_BIT = 0;
   localparam int IRQ_REFUSE_BIT = 1;
   localparam int IRQ_OPDONE_BIT = 2;
   localparam int IRQ_OPFAIL_BIT = 3;
   localparam int IRQ_W = 4;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam int CMP_CYCLES = 4;

   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_UNLOCK = 4'h1,
      CMD_RELOCK = 4'h2,
      CMD_STORE_KEY = 4'h3,
      CMD_STORE_DEC = 4'h4,
      CMD_SET_SEC = 4'h5,
      CMD_CHECK_DEC = 4'h6
   } cmd_t;

   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_VERIFY = 2'h1,
      OP_READ = 2'h2
   } op_t;

   typedef enum logic [1:0] {
      REG_ARRAY = 2'h0,
      REG_UNVM = 2'h1,
      REG_EMB = 2'h2
   } region_t;

   typedef struct packed {
      logic [2:0] enc_regions;
      logic enc;
      logic perm_set;
      logic perm_lock;
      logic part_lock;
      logic lock;
   } sec_cfg_t;

   typedef struct packed {
      logic valid;
      op_t op;
      region_t region;
      logic encrypted;
   } op_req_t;
endpackage
`default_nettype wire

// >>> rtl/key_store.sv
// key_store: key-word memory for the stored unlock and decryption keys.
// Assumes a single writer and registered read data.
`default_nettype none
module key_store
   import access_lock_pkg::*;
#(
   parameter int WORDS = 2 * KEY_WORDS
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic we,
   input wire logic [$clog2(WORDS)-1:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [$clog2(WORDS)-1:0] raddr,
   output logic [31:0] rdata
);
   logic [31:0] mem [WORDS];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= RST_WORD;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule // key_store
`default_nettype wire

// >>> rtl/access_lock.sv
// access_lock: APB-controlled security gate for program, verify and read operations.
// Assumes APB with no wait states beyond one cycle, and the programmer driving keys through it.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - With partial lock set, array writes are refused while array verify and user memory reads pass without a key.
// - With permanent lock set, array write and verify and user memory write and read are refused for good.
// - Once permanent settings are stored, every change to the security configuration is rejected.
// - With the lock option set, stored settings can change only after the matching unlock key has been presented.
// - The unlock key is 128 bits, supplied by the programmer and stored when the lock option is chosen.
// - The decryption key is 128 bits, supplied by the programmer and stored when encryption is chosen.
// - A mismatch of unlock key or decryption key refuses the unlock or image, and the operation fails.
module access_lock
   import access_lock_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   output logic OP_GRANT,
   output logic OP_DONE
);
   typedef enum {IDLE, CMP, FINISH} cmp_state_t;

   cmp_state_t state;
   logic [31:0] key_in [KEY_WORDS];
   sec_cfg_t cfg;
   sec_cfg_t set_word;
   logic unlocked;
   logic refuse;
   logic last_ok;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_en;
   logic [1:0] widx;
   logic mismatch;
   cmd_t pend_cmd;
   logic ks_we;
   logic [2:0] ks_waddr;
   logic [2:0] ks_raddr;
   logic [31:0] ks_rdata;
   logic [2:0] rd_cnt;
   logic setup;
   logic wr;
   logic rd;
   logic cmd_go;
   logic op_go;
   logic grant_ev;
   logic refuse_ev;
   logic opdone_ev;
   logic opfail_ev;
   logic op_ok;
   op_req_t req;
   logic addr_ok;
   logic cfg_frozen;

   assign setup = PSEL && !PENABLE;
   assign wr = PSEL && PENABLE && PREADY && PWRITE;
   assign rd = PSEL && PENABLE && PREADY && !PWRITE;
   assign cmd_go = wr && PADDR == OFF_CMD && state == IDLE;
   assign op_go = wr && PADDR == OFF_OP;
   assign cfg_frozen = cfg.perm_set || cfg.perm_lock;

   assign addr_ok = PADDR[1:0] == 2'b00 && (PADDR < OFF_KEY0 + 8'h10 || PADDR == OFF_CMD
      || PADDR == OFF_STATUS || PADDR == OFF_CFG || PADDR == OFF_IRQ_STAT
      || PADDR == OFF_IRQ_EN || PADDR == OFF_IRQ_CLR || PADDR == OFF_OP || PADDR == OFF_SET);

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // apb handshake: no wait cycle, pready is high in the first cycle of the access phase
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && !addr_ok;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // presented key words and the settings staging word
   genvar g;
   generate
      for (g = 0; g < KEY_WORDS; g++) begin : g_key
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
               key_in[g] <= RST_WORD;
            end else if (wr && PADDR == OFF_KEY0 + 8'(4 * g)) begin
               key_in[g] <= PWDATA;
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         set_word <= '0;
      end else if (wr && PADDR == OFF_SET) begin
         set_word <= sec_cfg_t'({PWDATA[CFG_ENC_REG_LSB +: 3], PWDATA[CFG_ENC_BIT],
            PWDATA[CFG_PERM_SET_BIT], PWDATA[CFG_PERM_LOCK_BIT], PWDATA[CFG_PART_BIT],
            PWDATA[CFG_LOCK_BIT]});
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // command sequencer: stores keys, or compares one stored key word per cycle
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state <= IDLE;
         pend_cmd <= CMD_NONE;
         rd_cnt <= 3'h0;
         widx <= 2'h0;
         mismatch <= 1'b0;
      end else begin
         case (state)
            IDLE: begin
               if (cmd_go && (cmd_t'(PWDATA[3:0]) == CMD_UNLOCK
                     || cmd_t'(PWDATA[3:0]) == CMD_CHECK_DEC)) begin
                  state <= CMP;
                  pend_cmd <= cmd_t'(PWDATA[3:0]);
                  rd_cnt <= 3'h0;
                  widx <= 2'h0;
                  mismatch <= 1'b0;
               end
            end
            CMP: begin
               rd_cnt <= rd_cnt + 3'h1;
               if (rd_cnt != 3'h0) begin
                  // full-width compare, word by word
                  if (ks_rdata != key_in[widx]) begin
                     mismatch <= 1'b1;
                  end
                  widx <= widx + 2'h1;
                  if (widx == 2'(KEY_WORDS - 1)) begin
                     state <= FINISH;
                  end
               end
            end
            FINISH: begin
               state <= IDLE;
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

   assign ks_raddr = (pend_cmd == CMD_CHECK_DEC ? 3'h4 : 3'h0) + {1'b0, rd_cnt[1:0]};

   always_comb begin
      ks_we = 1'b0;
      ks_waddr = 3'h0;
      if (cmd_go && !cfg_frozen && (unlocked || !cfg.lock)) begin
         if (cmd_t'(PWDATA[3:0]) == CMD_STORE_KEY && set_word.lock) begin
            ks_we = 1'b1;
            ks_waddr = {1'b0, PWDATA[5:4]};
         end else if (cmd_t'(PWDATA[3:0]) == CMD_STORE_DEC && set_word.enc) begin
            ks_we = 1'b1;
            ks_waddr = {1'b1, PWDATA[5:4]};
         end
      end
   end

   key_store #(
      .WORDS(2 * KEY_WORDS)
   ) u_key_store (
      .clk(CLK),
      .rst_b(RST_B),
      .we(ks_we),
      .waddr(ks_waddr),
      .wdata(key_in[PWDATA[5:4]]),
      .raddr(ks_raddr),
      .rdata(ks_rdata)
   );

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // unlock state, decryption check and settings
   logic cmp_end;
   logic dec_ok;
   assign cmp_end = state == FINISH;
   assign grant_ev = cmp_end && pend_cmd == CMD_UNLOCK && !mismatch;
   assign refuse_ev = cmp_end && pend_cmd == CMD_UNLOCK && mismatch;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         unlocked <= 1'b0;
         refuse <= 1'b0;
      end else if (grant_ev) begin
         unlocked <= 1'b1;
         refuse <= 1'b0;
      end else if (refuse_ev || (cmd_go && cmd_t'(PWDATA[3:0]) == CMD_RELOCK)) begin
         unlocked <= 1'b0;
         refuse <= refuse_ev;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         dec_ok <= 1'b0;
      end else if (cmp_end && pend_cmd == CMD_CHECK_DEC) begin
         dec_ok <= !mismatch;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cfg <= '0;
      end else if (cmd_go && cmd_t'(PWDATA[3:0]) == CMD_SET_SEC && !cfg_frozen
            && (unlocked || !cfg.lock)) begin
         cfg <= set_word;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // operation gate
   assign req = op_req_t'({1'b1, op_t'(PWDATA[OP_LSB +: 2]), region_t'(PWDATA[REG_LSB +: 2]),
      PWDATA[8]});

   always_comb begin
      op_ok = unlocked || !cfg.lock;
      if (cfg.part_lock && req.region == REG_ARRAY && req.op != OP_WRITE) begin
         op_ok = 1'b1;
      end
      if (cfg.part_lock && req.region == REG_UNVM && req.op == OP_READ) begin
         op_ok = 1'b1;
      end
      if (cfg.part_lock && req.region == REG_ARRAY && req.op == OP_WRITE) begin
         op_ok = 1'b0;
      end
      if (cfg.perm_lock && req.region == REG_ARRAY && req.op != OP_READ) begin
         op_ok = 1'b0;
      end
      if (cfg.perm_lock && req.region == REG_UNVM && req.op != OP_VERIFY) begin
         op_ok = 1'b0;
      end
      if (req.op == OP_WRITE && cfg.enc && cfg.enc_regions[req.region]
            && (!req.encrypted || !dec_ok)) begin
         op_ok = 1'b0;
      end
   end

   assign opdone_ev = op_go && op_ok;
   assign opfail_ev = op_go && !op_ok;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         OP_GRANT <= 1'b0;
         OP_DONE <= 1'b0;
         last_ok <= 1'b0;
      end else begin
         OP_GRANT <= opdone_ev;
         OP_DONE <= op_go;
         if (op_go) begin
            last_ok <= op_ok;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over clear
   logic [IRQ_W-1:0] irq_set;
   assign irq_set = {opfail_ev, opdone_ev, refuse_ev, grant_ev};

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         irq_stat <= '0;
         irq_en <= '0;
      end else begin
         if (wr && PADDR == OFF_IRQ_CLR) begin
            irq_stat <= (irq_stat & ~PWDATA[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         if (wr && PADDR == OFF_IRQ_EN) begin
            irq_en <= PWDATA[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |((irq_stat | irq_set) & irq_en);
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // read data; key registers are write-only and read as zero
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PRDATA <= RST_WORD;
      end else if (setup) begin
         case (PADDR)
            OFF_STATUS: PRDATA <= {28'h0, last_ok, state != IDLE, refuse, unlocked};
            OFF_CFG: PRDATA <= {21'h0, cfg.enc_regions, 3'h0, cfg.enc, cfg.perm_set,
               cfg.perm_lock, cfg.part_lock, cfg.lock};
            OFF_IRQ_STAT: PRDATA <= {28'h0, irq_stat};
            OFF_IRQ_EN: PRDATA <= {28'h0, irq_en};
            default: PRDATA <= RST_WORD;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////////
   // checks
   a_part_write_block: assert property (@(posedge CLK) disable iff (!RST_B)
      op_go && cfg.part_lock && req.region == REG_ARRAY && req.op == OP_WRITE |=> !OP_GRANT)
      else $error("array write granted under partial lock");
   a_part_verify_pass: assert property (@(posedge CLK) disable iff (!RST_B)
      op_go && cfg.part_lock && !cfg.perm_lock && req.region == REG_ARRAY
      && req.op == OP_VERIFY |=> OP_GRANT)
      else $error("array verify refused under partial lock");
   a_perm_block: assert property (@(posedge CLK) disable iff (!RST_B)
      op_go && cfg.perm_lock && req.region == REG_UNVM && req.op == OP_READ |=> !OP_GRANT)
      else $error("user memory read granted under permanent lock");
   a_perm_frozen: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg_frozen |=> cfg == $past(cfg) && !ks_we)
      else $error("settings changed after permanent setting");
   a_lock_guard: assert property (@(posedge CLK) disable iff (!RST_B)
      cfg.lock && !unlocked |=> $stable(cfg))
      else $error("settings changed while locked");
   a_store_key: assert property (@(posedge CLK) disable iff (!RST_B)
      ks_we |-> (ks_waddr[2] ? set_word.enc : set_word.lock))
      else $error("key stored without its option");
   a_refuse_flag: assert property (@(posedge CLK) disable iff (!RST_B)
      refuse_ev |=> refuse && !unlocked && irq_stat[IRQ_REFUSE_BIT])
      else $error("refusal not reported");
   a_cmp_len: assert property (@(posedge CLK) disable iff (!RST_B)
      cmd_go && cmd_t'(PWDATA[3:0]) == CMD_UNLOCK |=> state == CMP [*5] ##1 state == FINISH)
      else $error("compare did not cover all words");
   a_grant_exact: assert property (@(posedge CLK) disable iff (!RST_B)
      grant_ev |-> !mismatch ##1 unlocked)
      else $error("unlock granted on mismatch");
   c_unlock: cover property (@(posedge CLK) disable iff (!RST_B) grant_ev);
   c_refuse: cover property (@(posedge CLK) disable iff (!RST_B) refuse_ev);
   c_op_fail: cover property (@(posedge CLK) disable iff (!RST_B) opfail_ev);
   c_frozen: cover property (@(posedge CLK) disable iff (!RST_B) cfg_frozen && cmd_go);
endmodule // access_lock
`default_nettype wire

// >>> testbench/programmer_model.sv
// programmer_model: APB master standing in for the in-system programmer.
// Assumes a slave that raises pready in the access phase; the bench calls its tasks.
`default_nettype none
module programmer_model
   import access_lock_pkg::*;
(
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // released address and data show the inverse of the last value
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~addr;
      pwdata <= ~wd;
   endtask

   // a full key goes out as four words, low word first
   task automatic put_key(input logic [KEY_W-1:0] k);
      logic [31:0] rd;
      for (int i = 0; i < KEY_WORDS; i++) begin
         xfer(1'b1, OFF_KEY0 + 8'(4 * i), k[32*i +: 32], rd);
      end
   endtask

   // an image is sent encrypted for every region secured with encryption
   function automatic logic enc_for(input logic [2:0] regions, input region_t r);
      return regions[r];
   endfunction
endmodule // programmer_model
`default_nettype wire

// >>> testbench/programming_access_lock_tb.sv
// programming_access_lock_tb: self-checking bench for access_lock through the programmer model.
// Assumes the register map and command codes of access_lock_pkg.
`default_nettype none
module programming_access_lock_tb import access_lock_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_t;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, OP_GRANT, OP_DONE;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rdv;
   logic [KEY_W-1:0] keyu, keyd;
   exp_t exp_q[$];
   logic exp_op[$];
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;

   always #10 CLK = ~CLK;

   access_lock DUT (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .IRQ(IRQ), .OP_GRANT(OP_GRANT), .OP_DONE(OP_DONE));
   programmer_model u_prog (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
      .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY));

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      // an expected result that never showed up is a miss as well
      if (exp_q.size() + exp_op.size() != 0) begin
         n_fail++;
         $display("BAD %0t %0d results never seen", $time, exp_q.size() + exp_op.size());
      end
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic push(input logic [31:0] d, input logic [31:0] m, input logic e);
      exp_t x;
      x.d = d;
      x.m = m;
      x.e = e;
      exp_q.push_back(x);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
      push(32'h0, 32'h0, e);
      u_prog.xfer(1'b1, a, d, rdv);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic e = 1'b0);
      push(d, m, e);
      u_prog.xfer(1'b0, a, 32'h0, rdv);
   endtask

   // a new command only once busy has cleared
   task automatic cmd(input logic [31:0] c);
      logic [31:0] s;
      wr(OFF_CMD, c);
      s = 32'h4;
      while (s[ST_BUSY_BIT] !== 1'b0) begin
         push(32'h0, 32'h0, 1'b0);
         u_prog.xfer(1'b0, OFF_STATUS, 32'h0, s);
      end
   endtask

   task automatic key(input logic [KEY_W-1:0] k);
      repeat (KEY_WORDS) push(32'h0, 32'h0, 1'b0);
      u_prog.put_key(k);
   endtask

   task automatic op(input op_t o, input region_t r, input logic en, input logic g);
      exp_op.push_back(g);
      wr(OFF_OP, {23'h0, en, 2'h0, r, 2'h0, o});
   endtask

   task automatic irq_is(input logic v);
      repeat (3) @(posedge CLK);
      #1;
      chk_bit(IRQ, v);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // results are taken off the queues as they appear at the ports
   always @(posedge CLK) begin
      exp_t x;
      if (RST_B && PSEL && PENABLE && PREADY && exp_q.size() > 0) begin
         x = exp_q.pop_front();
         chk_bit(PSLVERR, x.e);
         if (!PWRITE && x.m != 32'h0) chk_data(PRDATA & x.m, x.d & x.m);
      end
      if (RST_B && OP_DONE === 1'b1 && exp_op.size() > 0) chk_bit(OP_GRANT, exp_op.pop_front());
   end

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h2B215E3E));
      keyu = {$urandom, $urandom, $urandom, $urandom};
      keyd = {$urandom, $urandom, $urandom, $urandom};
      repeat (5) @(posedge CLK);
      RST_B <= 1'b1;
      rd(OFF_STATUS, 32'h0, 32'hFF);
      rd(OFF_CFG, 32'h0, 32'hFFFF);
      rd(8'hF0, 32'h0, 32'h0, 1'b1);
      wr(8'hF4, 32'h1, 1'b1);
      op(OP_WRITE, REG_ARRAY, 1'b0, 1'b1);
      // lock and encryption options are staged before the key words are stored
      wr(OFF_SET, 32'h413);
      key(keyu);
      for (int i = 0; i < 4; i++) cmd(32'(CMD_STORE_KEY) | 32'(i << 4));
      key(keyd);
      for (int i = 0; i < 4; i++) cmd(32'(CMD_STORE_DEC) | 32'(i << 4));
      cmd(32'(CMD_SET_SEC));
      rd(OFF_CFG, 32'h413, 32'h7FF);
      cmd(32'(CMD_RELOCK));
      op(OP_WRITE, REG_ARRAY, 1'b0, 1'b0);
      op(OP_VERIFY, REG_ARRAY, 1'b0, 1'b1);
      op(OP_READ, REG_UNVM, 1'b0, 1'b1);
      op(OP_WRITE, REG_UNVM, 1'b0, 1'b0);
      rd(OFF_IRQ_STAT, 32'h8, 32'h8);
      key(keyu ^ (128'h1 << ($urandom % 128)));
      cmd(32'(CMD_UNLOCK));
      rd(OFF_STATUS, 32'h2, 32'h3);
      rd(OFF_IRQ_STAT, 32'h2, 32'h2);
      irq_is(1'b0);
      wr(OFF_IRQ_EN, 32'h2);
      irq_is(1'b1);
      wr(OFF_IRQ_CLR, 32'h2);
      irq_is(1'b0);
      rd(OFF_IRQ_STAT, 32'h0, 32'h2);
      wr(OFF_SET, 32'h0);
      cmd(32'(CMD_SET_SEC));
      rd(OFF_CFG, 32'h413, 32'h7FF);
      key(keyu);
      cmd(32'(CMD_UNLOCK));
      rd(OFF_STATUS, 32'h1, 32'h3);
      op(OP_WRITE, REG_UNVM, 1'b0, 1'b1);
      op(OP_WRITE, REG_ARRAY, 1'b0, 1'b0);
      // image keyed to the stored decryption key, once wrong and once right
      key(keyd ^ (128'h1 << ($urandom % 128)));
      cmd(32'(CMD_CHECK_DEC));
      op(OP_WRITE, REG_EMB, u_prog.enc_for(3'b100, REG_EMB), 1'b0);
      key(keyd);
      cmd(32'(CMD_CHECK_DEC));
      op(OP_WRITE, REG_EMB, u_prog.enc_for(3'b100, REG_EMB), 1'b1);
      wr(OFF_SET, 32'h417);
      cmd(32'(CMD_SET_SEC));
      rd(OFF_CFG, 32'h417, 32'h7FF);
      for (int o = 0; o < 3; o++) begin
         for (int r = 0; r < 2; r++) begin
            op(op_t'(o), region_t'(r), 1'b0, (r == 0) ? (o == 2) : (o == 1));
         end
      end
      wr(OFF_SET, 32'h0);
      cmd(32'(CMD_SET_SEC));
      rd(OFF_CFG, 32'h417, 32'h7FF);
      // a key store after the permanent setting must leave the old key in place
      key(~keyu);
      cmd(32'(CMD_STORE_KEY));
      key(keyu);
      cmd(32'(CMD_UNLOCK));
      rd(OFF_STATUS, 32'h1, 32'h3);
      repeat (4) @(posedge CLK);
      test_done();
   end
endmodule // programming_access_lock_tb
`default_nettype wire
